// ===== common/lpa_pkg.sv
/*
 * Constants and types shared by both ends of the linear pixel array readout link.
 * Assumes a single 10 MHz clock common to sequencer and sensor model.
 */
package lpa_pkg;
    localparam int LPA_PIXELS = 64;
    localparam int LPA_IDX_W = 6;
    localparam logic [5:0] LPA_FIRST_UP = 6'h00;
    localparam logic [5:0] LPA_FIRST_DOWN = 6'h3F;
    localparam int LPA_SAMPLE_W = 8;
    localparam int LPA_INTEG_DEFAULT = 100;
    localparam logic [1:0] LPA_HOLD_CYCLES = 2'h1;
    localparam logic [15:0] LPA_CNT_RESET = 16'h0000;

    typedef enum logic [1:0] {
        LPA_IDLE = 2'b00,
        LPA_INTEG = 2'b01,
        LPA_HOLD = 2'b10,
        LPA_SCAN = 2'b11
    } lpa_state_t;
endpackage

// ===== common/lpa_link_if.sv
/*
 * Link between the external sequencer and the pixel array sensor.
 * Assumes both ends run on the same clock, which the link itself does not carry.
 */
`timescale 1ns/10ps
`default_nettype none
interface lpa_link_if;
    import lpa_pkg::*;
    logic start_in;
    logic scan_direction_select;
    logic [LPA_SAMPLE_W-1:0] analog_pixel_out;
    logic pixel_valid;
    logic [LPA_IDX_W-1:0] pixel_index;
    logic chain_out;

    modport sensor (
        input start_in,
        input scan_direction_select,
        output analog_pixel_out,
        output pixel_valid,
        output pixel_index,
        output chain_out
    );
    modport sequencer (
        output start_in,
        output scan_direction_select,
        input analog_pixel_out,
        input pixel_valid,
        input pixel_index,
        input chain_out
    );
endinterface
`default_nettype wire

// ===== hw/lpa_sensor.sv
/*
 * Digital model of the 64-pixel linear sensor: integration, hold and scan.
 * Assumes start and direction arrive from logic on the same clock.
 */
// Function
// - Start sampled high begins integration everywhere
// - Sixty-four pixels take part each cycle
// - Each held pixel appears one clock
// - Shift register steps one pixel per clock
// - Odd and even bus lines alternate
// - Direction low scans up from zero
// - Direction high scans down from 63
// - Start still high restarts integration
// - Reset clears all internal registers
`timescale 1ns/10ps
`default_nettype none
module lpa_sensor
    import lpa_pkg::*;
#(
    parameter int PIXELS = LPA_PIXELS
) (
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire logic [PIXELS*LPA_SAMPLE_W-1:0] light_level_i,
    output logic integrating_o,
    lpa_link_if.sensor link
);
    localparam int PAIRS = PIXELS / 2;

    lpa_state_t state_reg;
    logic [LPA_SAMPLE_W-1:0] light_meta_reg [PIXELS];
    logic [LPA_SAMPLE_W-1:0] light_sync_reg [PIXELS];
    logic [LPA_SAMPLE_W-1:0] held_reg [PIXELS];
    logic [LPA_SAMPLE_W-1:0] even_line [PAIRS];
    logic [LPA_SAMPLE_W-1:0] odd_line [PAIRS];
    logic [LPA_SAMPLE_W-1:0] even_bus;
    logic [LPA_SAMPLE_W-1:0] odd_bus;
    logic [LPA_IDX_W-1:0] idx_reg;
    logic dir_reg;
    logic line_sel_reg;
    logic scanning;
    logic capture;
    logic last_pixel;

    // The six-bit pointer and the pairing of bus lines serve exactly this array length.
    if (PIXELS != LPA_PIXELS) begin : g_size_check
        $error("lpa_sensor serves exactly 64 pixels");
    end
    if ((1 << LPA_IDX_W) != PIXELS) begin : g_width_check
        $error("pixel pointer width does not match the array length");
    end

    assign scanning = (state_reg == LPA_SCAN);
    assign capture = (state_reg == LPA_INTEG) && !link.start_in;
    assign integrating_o = (state_reg == LPA_INTEG);

    // Descending scans end at pixel 0, ascending ones at the top pixel.
    always_comb begin
        if (dir_reg) begin
            last_pixel = (idx_reg == LPA_FIRST_UP);
        end else begin
            last_pixel = (idx_reg == LPA_FIRST_DOWN);
        end
    end

    // Sequence: idle, integrate while start is high, hold one clock, then scan.
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            state_reg <= LPA_IDLE;
        end else begin
            case (state_reg)
                LPA_IDLE: begin
                    if (link.start_in) begin
                        state_reg <= LPA_INTEG;
                    end
                end
                LPA_INTEG: begin
                    if (!link.start_in) begin
                        state_reg <= LPA_HOLD;
                    end
                end
                LPA_HOLD: begin
                    state_reg <= LPA_SCAN;
                end
                LPA_SCAN: begin
                    if (last_pixel && link.start_in) begin
                        state_reg <= LPA_INTEG;
                    end else if (last_pixel) begin
                        state_reg <= LPA_IDLE;
                    end
                end
                default: begin
                    state_reg <= LPA_IDLE;
                end
            endcase
        end
    end

    // Each pixel brings its light level across two flip-flops before anything reads it.
    for (genvar p = 0; p < PIXELS; p++) begin : g_pix
        always_ff @(posedge ref_clk_i) begin
            if (srst_i) begin
                light_meta_reg[p] <= '0;
                light_sync_reg[p] <= '0;
            end else begin
                light_meta_reg[p] <= light_level_i[p*LPA_SAMPLE_W +: LPA_SAMPLE_W];
                light_sync_reg[p] <= light_meta_reg[p];
            end
        end

        // All pixels are held on the same edge, when integration ends.
        always_ff @(posedge ref_clk_i) begin
            if (srst_i) begin
                held_reg[p] <= '0;
            end else if (capture) begin
                held_reg[p] <= light_sync_reg[p];
            end
        end
    end

    // Even pixels sit on one bus line and odd pixels on the other.
    for (genvar q = 0; q < PAIRS; q++) begin : g_pair
        assign even_line[q] = held_reg[2*q];
        assign odd_line[q] = held_reg[2*q+1];
    end

    // Direction is taken once per scan, at the hold edge.
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            dir_reg <= 1'b0;
        end else if (state_reg == LPA_HOLD) begin
            dir_reg <= link.scan_direction_select;
        end
    end

    // Shift pointer: loaded at hold, then one pixel further on every scan clock.
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            idx_reg <= LPA_FIRST_UP;
        end else if (state_reg == LPA_HOLD) begin
            if (link.scan_direction_select) begin
                idx_reg <= LPA_FIRST_DOWN;
            end else begin
                idx_reg <= LPA_FIRST_UP;
            end
        end else if (scanning) begin
            if (dir_reg) begin
                idx_reg <= idx_reg - 6'h01;
            end else begin
                idx_reg <= idx_reg + 6'h01;
            end
        end
    end

    // The control logic flips the bus line on every pixel, apart from the shift pointer.
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            line_sel_reg <= 1'b0;
        end else if (state_reg == LPA_HOLD) begin
            line_sel_reg <= link.scan_direction_select;
        end else if (scanning) begin
            line_sel_reg <= ~line_sel_reg;
        end
    end

    assign even_bus = even_line[idx_reg[LPA_IDX_W-1:1]];
    assign odd_bus = odd_line[idx_reg[LPA_IDX_W-1:1]];

    // Outputs come from flip-flops, so the sequencer samples settled values.
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            link.pixel_valid <= 1'b0;
        end else begin
            link.pixel_valid <= scanning;
        end
    end

    // The index tells the sequencer which pixel the sample belongs to.
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            link.pixel_index <= '0;
        end else begin
            link.pixel_index <= idx_reg;
        end
    end

    // One held voltage per clock, taken from the line that the control logic selects.
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            link.analog_pixel_out <= '0;
        end else begin
            link.analog_pixel_out <= line_sel_reg ? odd_bus : even_bus;
        end
    end

    // The chain pulse travels with the last pixel so that a following sensor can take over.
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            link.chain_out <= 1'b0;
        end else begin
            link.chain_out <= scanning && last_pixel;
        end
    end
endmodule
`default_nettype wire

// ===== hw/lpa_sequencer.sv
/*
 * External sequencer: issues start pulses and collects the scanned pixels.
 * Assumes the sensor shares ref_clk_i and drives its outputs from flip-flops.
 */
`timescale 1ns/10ps
`default_nettype none
module lpa_sequencer
    import lpa_pkg::*;
#(
    parameter int INTEG_CYCLES = LPA_INTEG_DEFAULT
) (
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire logic go_i,
    input wire logic continuous_i,
    input wire logic descending_i,
    output logic busy_o,
    output logic sample_valid_o,
    output logic [LPA_IDX_W-1:0] sample_index_o,
    output logic [LPA_SAMPLE_W-1:0] sample_data_o,
    output logic frame_done_o,
    lpa_link_if.sequencer link
);
    if (INTEG_CYCLES < 1 || INTEG_CYCLES > 65535) begin : g_integ_check
        $error("INTEG_CYCLES out of range");
    end

    logic [15:0] cnt_reg;
    logic run_reg;
    logic dir_reg;

    // Start is high for the integration interval, reloaded per frame when continuous.
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            cnt_reg <= LPA_CNT_RESET;
            run_reg <= 1'b0;
            dir_reg <= 1'b0;
        end else if (!run_reg && go_i) begin
            run_reg <= 1'b1;
            dir_reg <= descending_i;
            cnt_reg <= 16'(INTEG_CYCLES);
        end else if (run_reg && cnt_reg != LPA_CNT_RESET) begin
            cnt_reg <= cnt_reg - 16'h0001;
        end else if (run_reg && !continuous_i && link.chain_out) begin
            run_reg <= 1'b0;
        end else if (run_reg && continuous_i && link.chain_out) begin
            cnt_reg <= 16'(INTEG_CYCLES);
        end
    end

    // In continuous mode start rises again during the scan, so the sensor restarts at its end.
    assign link.start_in = run_reg
        && (cnt_reg != LPA_CNT_RESET || (continuous_i && link.pixel_valid));
    assign link.scan_direction_select = dir_reg;
    assign busy_o = run_reg;

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            sample_valid_o <= 1'b0;
            sample_index_o <= '0;
            sample_data_o <= '0;
            frame_done_o <= 1'b0;
        end else begin
            sample_valid_o <= link.pixel_valid;
            sample_index_o <= link.pixel_index;
            sample_data_o <= link.analog_pixel_out;
            frame_done_o <= link.chain_out;
        end
    end
endmodule
`default_nettype wire

// ===== verif/lpa_link_sva.sv
/* Checker for the link between sequencer and sensor.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/10ps
`default_nettype none
module lpa_link_sva
    import lpa_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire logic start_in,
    input wire logic scan_direction_select,
    input wire logic [LPA_SAMPLE_W-1:0] analog_pixel_out,
    input wire logic pixel_valid,
    input wire logic [LPA_IDX_W-1:0] pixel_index,
    input wire logic chain_out
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (srst_i);
    wire logic dn = scan_direction_select;
    index_step_a: assert property (pixel_valid && $past(pixel_valid) |->
        pixel_index == $past(pixel_index) + (dn ? 6'h3F : 6'h01)) else $error("bad step");
    first_index_a: assert property ($rose(pixel_valid) |->
        pixel_index == (dn ? 6'h3F : 6'h00)) else $error("bad first index");
    line_alternate_a: assert property (pixel_valid && $past(pixel_valid) |->
        pixel_index[0] != $past(pixel_index[0])) else $error("lines not alternating");
    scan_length_a: assert property ($rose(pixel_valid) |->
        ##63 chain_out ##1 !pixel_valid) else $error("bad scan length");
    chain_end_a: assert property (chain_out |->
        pixel_valid && pixel_index == (dn ? 6'h00 : 6'h3F)) else $error("bad chain pulse");
    hold_delay_a: assert property ($fell(start_in) |->
        ##[1:3] $rose(pixel_valid)) else $error("no scan after capture");
    dir_stable_a: assert property (pixel_valid |-> $stable(dn)) else $error("dir moved");
    reset_clear_a: assert property (disable iff (1'b0) srst_i |=>
        !pixel_valid && !chain_out && !start_in) else $error("reset left state");
endmodule
`default_nettype wire

// ===== verif/linear_pixel_array_readout_tb.sv
/* Bench joining sequencer and sensor over the link, with the checker beside it.
   Assumes package, interface, design and checker are compiled first. */
`timescale 1ns/10ps
`default_nettype none
module linear_pixel_array_readout_tb;
    import lpa_pkg::*;
    logic ref_clk_i = 1'b0, srst_i = 1'b1, go_i = 1'b0, continuous_i = 1'b0, descending_i = 1'b0;
    logic busy_o, sample_valid_o, frame_done_o, integrating_o;
    logic [LPA_IDX_W-1:0] sample_index_o;
    logic [LPA_SAMPLE_W-1:0] sample_data_o;
    logic [LPA_PIXELS*LPA_SAMPLE_W-1:0] light_level_i;
    int miscompares = 0, n_checks = 0, cycles = 0;
    lpa_link_if link ();
    lpa_sequencer #(.INTEG_CYCLES(4)) lpa_sequencer_i (.ref_clk_i, .srst_i, .go_i, .continuous_i,
        .descending_i, .busy_o, .sample_valid_o, .sample_index_o, .sample_data_o, .frame_done_o,
        .link);
    lpa_sensor lpa_sensor_i (.ref_clk_i, .srst_i, .light_level_i, .integrating_o, .link);
    lpa_link_sva lpa_link_sva_i (.ref_clk_i, .srst_i, .start_in(link.start_in),
        .scan_direction_select(link.scan_direction_select), .pixel_valid(link.pixel_valid),
        .analog_pixel_out(link.analog_pixel_out), .pixel_index(link.pixel_index),
        .chain_out(link.chain_out));
    always #50 ref_clk_i = ~ref_clk_i;
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic scan(input logic d);
        int k;
        int done;
        int integ;
        k = 0;
        done = 0;
        integ = 0;
        descending_i = d;
        go_i = 1'b1;
        @(posedge ref_clk_i) #1;
        go_i = 1'b0;
        repeat (120) begin
            @(posedge ref_clk_i) #1;
            if (integrating_o === 1'b1) integ = 1;
            if (frame_done_o === 1'b1) done++;
            if (sample_valid_o === 1'b1) begin
                chk(8'(sample_index_o), d ? 8'(63 - k) : 8'(k));
                chk(sample_data_o, 8'((d ? 63 - k : k) * 5 + 3));
                k++;
            end
        end
        chk(8'(k), 8'h40);
        chk(8'(done), 8'h01);
        chk(8'(integ), 8'h01);
        chk(8'(busy_o), 8'h00);
        $display("scan test done, direction %0d", d);
    endtask
    task automatic reset_mid_scan();
        go_i = 1'b1;
        @(posedge ref_clk_i) #1;
        go_i = 1'b0;
        repeat (30) @(posedge ref_clk_i) #1;
        srst_i = 1'b1;
        repeat (3) @(posedge ref_clk_i) #1;
        chk(8'({busy_o, sample_valid_o, integrating_o, link.pixel_valid}), 8'h00);
        srst_i = 1'b0;
        $display("reset test done");
    endtask
    task automatic scan_continuous();
        int k;
        int frames;
        k = 0;
        frames = 0;
        descending_i = 1'b0;
        continuous_i = 1'b1;
        go_i = 1'b1;
        @(posedge ref_clk_i) #1;
        go_i = 1'b0;
        repeat (200) begin
            @(posedge ref_clk_i) #1;
            if (sample_valid_o === 1'b1) begin
                chk(8'(sample_index_o), 8'(k % 64));
                chk(sample_data_o, 8'((k % 64) * 5 + 3));
                k++;
            end
            if (frame_done_o === 1'b1) begin
                frames++;
                continuous_i = 1'b0;
                chk(8'(integrating_o), (frames == 1) ? 8'h01 : 8'h00);
            end
        end
        chk(8'(k), 8'h80);
        chk(8'(frames), 8'h02);
        chk(8'(busy_o), 8'h00);
        $display("continuous test done");
    endtask
    initial begin
        for (int p = 0; p < LPA_PIXELS; p++) light_level_i[p*8+:8] = 8'(p * 5 + 3);
        repeat (16) @(posedge ref_clk_i);
        #1 srst_i = 1'b0;
        scan(1'b0);
        scan(1'b1);
        reset_mid_scan();
        scan(1'b0);
        scan_continuous();
        conclude();
    end
    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 2000) begin
            miscompares++;
            conclude();
        end
    end
endmodule
`default_nettype wire
